// File: hbs_status.sv
// Bridge status word: sticky link error flags plus hardwired capability bits
`timescale 1ns/1ns
`include "hbs_defines.svh"

module hbs_status
    import hbs_pkg::*;
(
    input  wire logic         clock_i,   // 100 MHz clock
    input  wire logic         resetn_i,  // Synchronous reset, active low
    input  wire hbs_cfg_req_s cfg_i,     // Config access, same clock
    input  wire hbs_events_s  events_i,  // Link error events, same clock
    output logic [15:0]       rdata_o,   // Read data, valid one cycle after addr
    output logic [15:0]       status_o   // Live status word
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    hbs_state_s state;       // Registered state
    hbs_state_s next_state;  // Next value

    // Compose the full word from flags and hardwired bits
    function automatic logic [15:0] hbs_word(input logic s, input logic u, input logic a);
        logic [15:0] w;
        w = `HBS_STATUS_RESET;
        w[`HBS_BIT_PARITY_DET] = 1'b0;
        w[`HBS_BIT_SERR_SENT]  = s;
        w[`HBS_BIT_UNSUP_CPL]  = u;
        w[`HBS_BIT_CPL_ABORT]  = a;
        return w;
    endfunction

    logic hit_wr;   // Write hits the status word with high byte enabled
    logic [15:0] clr; // Write-one-to-clear mask

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    // Set wins over clear so an event in the clearing cycle is kept
    always_comb begin
        hit_wr = cfg_i.wr && (cfg_i.addr == `HBS_STATUS_OFFSET) && cfg_i.be[1];
        clr    = hit_wr ? cfg_i.wdata : 16'h0000;
        next_state = state;
        // Flags clear only on a written one; zeros leave them
        next_state.serr_sent = events_i.serr_sent |
                               (state.serr_sent & ~clr[`HBS_BIT_SERR_SENT]);
        next_state.unsup_cpl = events_i.unsup_cpl |
                               (state.unsup_cpl & ~clr[`HBS_BIT_UNSUP_CPL]);
        next_state.cpl_abort = events_i.cpl_abort |
                               (state.cpl_abort & ~clr[`HBS_BIT_CPL_ABORT]);
        // Only the status offset returns data; other offsets read zero
        if (cfg_i.addr == `HBS_STATUS_OFFSET) begin
            next_state.rdata = hbs_word(state.serr_sent, state.unsup_cpl,
                                        state.cpl_abort);
        end else begin
            next_state.rdata = 16'h0000;
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state <= '{serr_sent: 1'b0, unsup_cpl: 1'b0, cpl_abort: 1'b0,
                       rdata: 16'h0000};
        end else begin
            state <= next_state;
        end
    end

    assign rdata_o  = state.rdata;
    assign status_o = hbs_word(state.serr_sent, state.unsup_cpl, state.cpl_abort);

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    a_reset_value: assert property (@(posedge clock_i)
        !resetn_i |=> status_o == 16'h0090)
        else $error("Status not 0090 after reset");
    a_parity_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !status_o[15] && !status_o[8])
        else $error("Parity bits not zero");
    a_serr_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
        events_i.serr_sent |=> status_o[14])
        else $error("System error flag not set");
    a_flag_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
        status_o[13] && !(hit_wr && cfg_i.wdata[13]) |=> status_o[13])
        else $error("Unsupported flag dropped without clear");
    a_flag_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
        hit_wr && cfg_i.wdata[12] && !events_i.cpl_abort |=> !status_o[12])
        else $error("Abort flag not cleared by one");
    a_unsup_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
        events_i.unsup_cpl |=> status_o[13])
        else $error("Unsupported flag not set");
    a_abort_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
        events_i.cpl_abort |=> status_o[12])
        else $error("Abort flag not set");
    a_fixed_bits: assert property (@(posedge clock_i) disable iff (!resetn_i)
        status_o[11:9] == 3'h0 && status_o[7] && !status_o[5])
        else $error("Hardwired bits wrong");
    a_read_data: assert property (@(posedge clock_i) disable iff (!resetn_i)
        cfg_i.addr == 8'h06 |=> rdata_o == $past(status_o))
        else $error("Read data mismatch");

    c_serr_clear: cover property (@(posedge clock_i) disable iff (!resetn_i)
        status_o[14] && hit_wr && cfg_i.wdata[14]);
    c_set_on_clear: cover property (@(posedge clock_i) disable iff (!resetn_i)
        events_i.unsup_cpl && hit_wr && cfg_i.wdata[13]);
    c_all_flags: cover property (@(posedge clock_i) disable iff (!resetn_i)
        status_o[14:12] == 3'h7);

endmodule

// File: hbs_defines.svh
// Offsets, field positions, reset value and bus widths of the bridge status word
//
// Contract
// - 16-bit status at offset 06h, reset 0090h
// - Bit 15 parity flag reads zero always
// - Bit 14 sets when system error sent
// - Flags stay set until software writes one
// - Bit 13 sets on unsupported request completion
// - Bit 12 sets on completer abort completion
// - Bit 11 hardwired zero, no aborts sent
// - Bits 10:9 always read 00, fast decode
// - Bit 8 master parity flag reads zero
// - Bit 7 hardwired one, back-to-back capable
// - Bit 5 hardwired zero, no 66 MHz
`ifndef HBS_DEFINES_SVH
`define HBS_DEFINES_SVH

// -----------------------------------------------------------------
// Register map
// -----------------------------------------------------------------
`define HBS_STATUS_OFFSET     8'h06
`define HBS_ADDR_W            8
`define HBS_DATA_W            16
`define HBS_STATUS_RESET      16'h0090

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define HBS_BIT_PARITY_DET    15
`define HBS_BIT_SERR_SENT     14
`define HBS_BIT_UNSUP_CPL     13
`define HBS_BIT_CPL_ABORT     12
`define HBS_BIT_ABORT_SIG     11
`define HBS_BIT_TIMING_HI     10
`define HBS_BIT_TIMING_LO     9
`define HBS_BIT_MASTER_PAR    8
`define HBS_BIT_B2B_CAPABLE   7
`define HBS_BIT_66MHZ         5

`endif

// File: hbs_pkg.sv
// Types shared by the bridge status word block
package hbs_pkg;

    // Configuration access request from the config space decoder
    typedef struct packed {
        logic        wr;    // Write strobe, one cycle
        logic [7:0]  addr;  // Config byte offset
        logic [1:0]  be;    // Byte enables for the 16-bit word
        logic [15:0] wdata; // Write data
    } hbs_cfg_req_s;

    // Error events seen on the upstream link, one-cycle pulses
    typedef struct packed {
        logic serr_sent;  // System error message sent
        logic unsup_cpl;  // Unsupported Request completion received
        logic cpl_abort;  // Completer Abort completion received
    } hbs_events_s;

    // Whole state of the block
    typedef struct packed {
        logic        serr_sent;
        logic        unsup_cpl;
        logic        cpl_abort;
        logic [15:0] rdata;
    } hbs_state_s;

endpackage

// File: hbs_link_model.sv
// Upstream link partner: sparse random error event pulses
`timescale 1ns/1ns

module hbs_link_model
    import hbs_pkg::*;
#(
    parameter int SEED = 32'h2b61  // Private seed, value arbitrary
)
(
    input  wire logic  clock_i,   // Bench clock
    input  wire logic  active_i,  // Events allowed
    output hbs_events_s events_o  // Event pulses to the bridge
);
    integer seed_q = SEED;  // Own stream, repeatable
    initial events_o = '0;
    // Launch just after each edge; ANDed draws keep pulses sparse
    always @(posedge clock_i) begin
        #1 events_o = active_i ? 3'($random(seed_q) & $random(seed_q)) : 3'h0;
    end
endmodule

// File: hbs_status_tb.sv
// Self-checking bench for the bridge status word
`timescale 1ns/1ns
`include "hbs_defines.svh"
`define HBS_CHECK(g, w) begin checked++; if ((g) !== (w)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, g, w); end end

module hbs_status_tb
    import hbs_pkg::*;
;
    logic         clock_i;   // 100 MHz
    logic         resetn_i;  // Active low
    logic         active;    // Partner events on
    hbs_cfg_req_s cfg;       // Config request
    hbs_events_s  ev;        // Link events
    logic [15:0]  rdata;     // Registered read data
    logic [15:0]  status;    // Live word
    logic [2:0]   exp_f;     // Expected sticky flags
    integer       seed = 32'h7185;
    integer       failures = 0;
    integer       checked = 0;
    integer       i;

    hbs_status dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .cfg_i(cfg),
        .events_i(ev), .rdata_o(rdata), .status_o(status));
    hbs_link_model link_u (.clock_i(clock_i), .active_i(active), .events_o(ev));

    // Whole word from flags; constant bits fixed
    function automatic logic [15:0] word(input logic [2:0] f);
        return {1'b0, f, 4'h0, 8'h90};
    endfunction

    // Reference flags; a set in the same cycle beats a clear
    always @(posedge clock_i) begin
        if (!resetn_i) exp_f = 3'h0;
        else exp_f = (exp_f & ~((cfg.wr && cfg.addr == `HBS_STATUS_OFFSET && cfg.be[1])
            ? cfg.wdata[14:12] : 3'h0)) | ev;
    end

    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clock_i = 0;
        forever #5 clock_i = ~clock_i;
    end
    // Watchdog well past the ~420 cycles of the run
    initial begin
        #100000;
        failures++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn_i = 0;
        active = 0;
        cfg = '0;
        repeat (8) @(posedge clock_i);
        #1 resetn_i = 1;
        @(negedge clock_i);
        `HBS_CHECK(status, 16'h0090)
        `HBS_CHECK(rdata, 16'h0000)
        for (i = 0; i < 400; i++) begin
            @(posedge clock_i);
            #1;
            active = (i < 300);  // Quiet tail lets clears stick
            cfg.wr = 1'($random(seed));
            cfg.be = 2'($random(seed));
            cfg.wdata = 16'($random(seed));
            cfg.addr = 1'($random(seed)) ? `HBS_STATUS_OFFSET : 8'($random(seed));
            // Corner: clear all flags with only the high byte enabled
            if (i == 320) cfg = '{1'b1, `HBS_STATUS_OFFSET, 2'b10, 16'h7000};
            @(negedge clock_i);
            `HBS_CHECK(status, word(exp_f))
            `HBS_CHECK(status[15], 1'b0)
            `HBS_CHECK(status[11], 1'b0)
            `HBS_CHECK(status[10:9], 2'b00)
            `HBS_CHECK(status[8], 1'b0)
            `HBS_CHECK(status[7], 1'b1)
            `HBS_CHECK(status[5], 1'b0)
        end
        // Reads at the status offset and at an unmapped one
        @(posedge clock_i);
        #1 cfg = '{1'b0, `HBS_STATUS_OFFSET, 2'b11, 16'h0000};
        @(posedge clock_i);
        #1 cfg.addr = 8'h04;
        `HBS_CHECK(rdata, word(exp_f))
        @(posedge clock_i);
        #1;
        `HBS_CHECK(rdata, 16'h0000)
        summarize();
    end
endmodule
